// ---- design/sbh_store_buffer_hazard_unit.v ----
// Single-entry store buffer with load conflict detection and split circular loads
//
// Contract
// - Loads start memory access in decode stage, stores one stage later in execute.
// - Exactly one store buffer entry resolves store-then-load port contention.
// - Local store in execute with load in decode is parked; load accesses first.
// - Buffered store drains on the next store or an idle port cycle.
// - Only local RAM or cache stores are buffered; bus stores go immediately, in order.
// - Conflict when any requested load byte is held in the store buffer.
// - On conflict the load is cancelled, buffer written, then the conflicting access (first, or wrapped base) retried.
// - With translation active and either side translated, compare address bits 9:0 only.
// - Without active translation, conflict compare uses the full address.
// - Wrapping circular word load splits: top of buffer first, then its base.
// - The wrapped second access is checked against the store buffer too.
// - Wrap is seen when a circular item crosses the buffer limit.
`timescale 1ns/1ps
`include "sbh_consts.vh"

module sbh_store_buffer_hazard_unit (
	// Clock, reset, enable
	input wire mclk,
	input wire sys_rst,
	input wire clkEn,
	// Translation control
	input wire mmuEnable,
	// Decode-stage load request
	input wire ldValid,
	input wire [31:0] ldAddr,
	input wire [1:0] ldSize,
	input wire ldTranslated,
	input wire ldCirc,
	input wire [31:0] circBase,
	input wire [15:0] circIndex,
	input wire [15:0] circLength,
	output reg ldAccept,
	output reg ldCancel,
	// Execute-stage store request
	input wire stValid,
	input wire [31:0] stAddr,
	input wire [3:0] stByteEn,
	input wire [31:0] stData,
	input wire stLocal,
	input wire stTranslated,
	output reg stAccept,
	// Memory port towards local data RAM or data cache
	output reg memReq,
	output reg memWrite,
	output reg [31:0] memAddr,
	output reg [3:0] memByteEn,
	output reg [31:0] memWData,
	output reg memSplitSecond,
	// Buffer status
	output wire bufOccupied
);

	// ==========================================================
	// Helpers

	// Lane mask for n bytes from a byte offset inside one word
	function [3:0] laneMask;
		input [1:0] off;
		input [2:0] n;
		reg [7:0] ones;
		begin
			ones = (8'h01 << n) - 8'h01;
			laneMask = 4'h0;
			laneMask = ones[3:0] << off;
		end
	endfunction

	// ==========================================================
	// State

	localparam [1:0] ST_IDLE = `SBH_ST_IDLE;
	localparam [1:0] ST_SECOND = `SBH_ST_SECOND;
	reg [1:0] state;
	reg bufValid;
	reg [31:0] bufAddr;
	reg [3:0] bufMask;
	reg [31:0] bufData;
	reg bufTrans;
	reg [31:0] secAddr;
	reg [3:0] secMask;
	reg secTrans;

	reg [1:0] next_state;
	reg next_bufValid;
	reg [31:0] next_bufAddr;
	reg [3:0] next_bufMask;
	reg [31:0] next_bufData;
	reg next_bufTrans;
	reg [31:0] next_secAddr;
	reg [3:0] next_secMask;
	reg next_secTrans;
	reg next_memReq;
	reg next_memWrite;
	reg [31:0] next_memAddr;
	reg [3:0] next_memByteEn;
	reg [31:0] next_memWData;
	reg next_memSplitSecond;

	assign bufOccupied = bufValid;

	// ==========================================================
	// First access geometry and wrap detection

	wire [2:0] ldBytes = 3'h1 << ldSize;
	wire [16:0] ldEnd = {1'b0, circIndex} + {14'h0, ldBytes};
	wire ldWrap = ldCirc && (ldEnd > {1'b0, circLength});
	wire [15:0] topBytesFull = circLength - circIndex;
	wire [2:0] topBytes = topBytesFull[2:0];
	wire [2:0] baseBytes = ldBytes - topBytes;
	wire [31:0] acc1Addr = ldCirc ? (circBase + {16'h0, circIndex}) : ldAddr;
	wire [3:0] acc1Mask = laneMask(acc1Addr[1:0], ldWrap ? topBytes : ldBytes);
	wire [3:0] acc2Mask = laneMask(circBase[1:0], baseBytes);

	// ==========================================================
	// Conflict compare against the buffered store

	// Page bits only when translation may move the upper address bits
	wire pageOnly1 = mmuEnable && (bufTrans || ldTranslated);
	wire pageOnly2 = mmuEnable && (bufTrans || secTrans);
	wire hiMatch1 = (acc1Addr[`SBH_FULL_MSB:`SBH_PAGE_MSB+1] ==
		bufAddr[`SBH_FULL_MSB:`SBH_PAGE_MSB+1]);
	wire hiMatch2 = (secAddr[`SBH_FULL_MSB:`SBH_PAGE_MSB+1] ==
		bufAddr[`SBH_FULL_MSB:`SBH_PAGE_MSB+1]);
	wire loMatch1 = (acc1Addr[`SBH_PAGE_MSB:`SBH_CMP_LSB] ==
		bufAddr[`SBH_PAGE_MSB:`SBH_CMP_LSB]);
	wire loMatch2 = (secAddr[`SBH_PAGE_MSB:`SBH_CMP_LSB] ==
		bufAddr[`SBH_PAGE_MSB:`SBH_CMP_LSB]);
	// Overlap checked per byte lane, not only per word
	wire conflict1 = bufValid && loMatch1 && (pageOnly1 || hiMatch1) &&
		(|(acc1Mask & bufMask));
	wire conflict2 = bufValid && loMatch2 && (pageOnly2 || hiMatch2) &&
		(|(secMask & bufMask));

	// ==========================================================
	// Port arbitration and next state
	always @* begin
		next_state = state;
		next_bufValid = bufValid;
		next_bufAddr = bufAddr;
		next_bufMask = bufMask;
		next_bufData = bufData;
		next_bufTrans = bufTrans;
		next_secAddr = secAddr;
		next_secMask = secMask;
		next_secTrans = secTrans;
		next_memReq = 1'b0;
		next_memWrite = 1'b0;
		next_memAddr = memAddr;
		next_memByteEn = memByteEn;
		next_memWData = memWData;
		next_memSplitSecond = 1'b0;
		ldAccept = 1'b0;
		ldCancel = 1'b0;
		stAccept = 1'b0;
		case (state)
			ST_IDLE: begin
				if (ldValid && conflict1) begin
					// Cancel the load and commit the entry; load comes back next cycle
					ldCancel = 1'b1;
					next_memReq = 1'b1;
					next_memWrite = 1'b1;
					next_memAddr = bufAddr;
					next_memByteEn = bufMask;
					next_memWData = bufData;
					next_bufValid = 1'b0;
				end else if (stValid && bufValid) begin
					// Older entry first keeps store order; new store waits a cycle
					next_memReq = 1'b1;
					next_memWrite = 1'b1;
					next_memAddr = bufAddr;
					next_memByteEn = bufMask;
					next_memWData = bufData;
					next_bufValid = 1'b0;
				end else if (stValid && (!ldValid || !stLocal)) begin
					// Store issues from execute; a bus store holds the load back
					stAccept = 1'b1;
					next_memReq = 1'b1;
					next_memWrite = 1'b1;
					next_memAddr = {stAddr[31:2], 2'h0};
					next_memByteEn = stByteEn;
					next_memWData = stData;
				end else if (ldValid) begin
					// Load issues from decode; a local store beside it is parked
					if (stValid) begin
						stAccept = 1'b1;
						next_bufValid = 1'b1;
						next_bufAddr = {stAddr[31:2], 2'h0};
						next_bufMask = stByteEn;
						next_bufData = stData;
						next_bufTrans = stTranslated;
					end
					next_memReq = 1'b1;
					next_memAddr = {acc1Addr[31:2], 2'h0};
					next_memByteEn = acc1Mask;
					if (ldWrap) begin
						next_state = ST_SECOND;
						next_secAddr = circBase;
						next_secMask = acc2Mask;
						next_secTrans = ldTranslated;
					end else begin
						ldAccept = 1'b1;
					end
				end else if (bufValid) begin
					// Idle port cycle drains the entry
					next_memReq = 1'b1;
					next_memWrite = 1'b1;
					next_memAddr = bufAddr;
					next_memByteEn = bufMask;
					next_memWData = bufData;
					next_bufValid = 1'b0;
				end
			end
			ST_SECOND: begin
				if (conflict2) begin
					// Wrapped half hits the entry: flush, then retry the base access
					ldCancel = 1'b1;
					next_memReq = 1'b1;
					next_memWrite = 1'b1;
					next_memAddr = bufAddr;
					next_memByteEn = bufMask;
					next_memWData = bufData;
					next_bufValid = 1'b0;
				end else begin
					ldAccept = 1'b1;
					next_memReq = 1'b1;
					next_memAddr = {secAddr[31:2], 2'h0};
					next_memByteEn = secMask;
					next_memSplitSecond = 1'b1;
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// Registers, frozen while the clock enable is low
	always @(posedge mclk) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			bufValid <= 1'b0;
			bufAddr <= `SBH_RST_ADDR;
			bufMask <= `SBH_RST_MASK;
			bufData <= `SBH_RST_DATA;
			bufTrans <= 1'b0;
			secAddr <= `SBH_RST_ADDR;
			secMask <= `SBH_RST_MASK;
			secTrans <= 1'b0;
			memReq <= 1'b0;
			memWrite <= 1'b0;
			memAddr <= `SBH_RST_ADDR;
			memByteEn <= `SBH_RST_MASK;
			memWData <= `SBH_RST_DATA;
			memSplitSecond <= 1'b0;
		end else if (clkEn) begin
			state <= next_state;
			bufValid <= next_bufValid;
			bufAddr <= next_bufAddr;
			bufMask <= next_bufMask;
			bufData <= next_bufData;
			bufTrans <= next_bufTrans;
			secAddr <= next_secAddr;
			secMask <= next_secMask;
			secTrans <= next_secTrans;
			memReq <= next_memReq;
			memWrite <= next_memWrite;
			memAddr <= next_memAddr;
			memByteEn <= next_memByteEn;
			memWData <= next_memWData;
			memSplitSecond <= next_memSplitSecond;
		end
	end

endmodule // sbh_store_buffer_hazard_unit

// ---- pkg/sbh_consts.vh ----
// Constants for the store buffer hazard unit
`ifndef SBH_CONSTS_VH
`define SBH_CONSTS_VH

// ==========================================================
// Controller states
`define SBH_ST_IDLE 2'h0
`define SBH_ST_SECOND 2'h1

// ==========================================================
// Load size codes (bytes = 1 << code)
`define SBH_SIZE_BYTE 2'h0
`define SBH_SIZE_HALF 2'h1
`define SBH_SIZE_WORD 2'h2

// ==========================================================
// Conflict compare fields
`define SBH_CMP_LSB 2
`define SBH_PAGE_MSB 9
`define SBH_FULL_MSB 31

// ==========================================================
// Reset values
`define SBH_RST_ADDR 32'h00000000
`define SBH_RST_DATA 32'h00000000
`define SBH_RST_MASK 4'h0

`endif

// ---- sim/sbh_mem_model.sv ----
// Memory port model standing in for local data RAM and the data cache
`timescale 1ns/1ps
module sbh_mem_model (
	// Access port
	input wire mclk, input wire memReq, input wire memWrite,
	input wire [31:0] memAddr, input wire [3:0] memByteEn, input wire [31:0] memWData
);
	logic [31:0] mem [logic [29:0]];
	logic [30:0] trace [$];
	// ==========
	// Merge written lanes; keep access order so the bench can judge overtaking
	always @(posedge mclk) begin
		if (memReq) begin
			trace.push_back({memWrite, memAddr[31:2]});
			if (memWrite && !mem.exists(memAddr[31:2])) mem[memAddr[31:2]] = 32'h0;
			for (int i = 0; i < 4; i++)
				if (memWrite && memByteEn[i]) mem[memAddr[31:2]][8*i+:8] = memWData[8*i+:8];
		end
	end
endmodule // sbh_mem_model

// ---- sim/sbh_assertions.sv ----
// Port checker for the store buffer hazard unit
`timescale 1ns/1ps
module sbh_checker (
	// Watched ports
	input wire mclk, input wire sys_rst, input wire clkEn,
	input wire ldValid, input wire [31:0] ldAddr, input wire [1:0] ldSize, input wire ldCirc,
	input wire [15:0] circIndex, input wire [15:0] circLength,
	input wire ldAccept, input wire ldCancel, input wire stValid, input wire [31:0] stAddr,
	input wire [31:0] stData, input wire stLocal, input wire stAccept,
	input wire memReq, input wire memWrite, input wire [31:0] memAddr,
	input wire [31:0] memWData, input wire memSplitSecond, input wire bufOccupied
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// ==========
	// Handshake decisions show up on the port one cycle later
	property p_park; clkEn && ldAccept && stAccept && stLocal
		|=> bufOccupied && memReq && !memWrite; endproperty
	a_park: assert property (p_park) else $error("parked store did not let load go first");
	property p_ldIssue; clkEn && ldAccept && !ldCirc
		|=> memReq && !memWrite && memAddr[31:2] == $past(ldAddr[31:2]); endproperty
	a_ldIssue: assert property (p_ldIssue) else $error("load access missing");
	property p_bus; clkEn && stAccept && !stLocal
		|=> memReq && memWrite && memAddr[31:2] == $past(stAddr[31:2]); endproperty
	a_bus: assert property (p_bus) else $error("bus store not issued at once");
	property p_stIdle; clkEn && stAccept && !ldValid && !bufOccupied
		|=> memReq && memWrite && memWData == $past(stData); endproperty
	a_stIdle: assert property (p_stIdle) else $error("lone store not written");
	property p_single; clkEn && bufOccupied && stValid |-> !stAccept; endproperty
	a_single: assert property (p_single) else $error("second store taken while full");
	property p_drain; clkEn && bufOccupied && !ldValid
		|=> memReq && memWrite && !bufOccupied; endproperty
	a_drain: assert property (p_drain) else $error("buffer not drained");
	property p_cancel; clkEn && ldCancel
		|-> bufOccupied && ldValid ##1 memReq && memWrite && !bufOccupied; endproperty
	a_cancel: assert property (p_cancel) else $error("cancel without drain");
	property p_split; clkEn && ldAccept && ldCirc && ldSize == 2'h2
		&& {1'b0, circIndex} + 17'h4 > {1'b0, circLength}
		|=> memSplitSecond && memReq && !memWrite; endproperty
	a_split: assert property (p_split) else $error("wrapped half missing");
endmodule // sbh_checker

bind sbh_store_buffer_hazard_unit sbh_checker chk (.mclk(mclk), .sys_rst(sys_rst),
	.clkEn(clkEn), .ldValid(ldValid), .ldAddr(ldAddr), .ldSize(ldSize), .ldCirc(ldCirc),
	.circIndex(circIndex), .circLength(circLength), .ldAccept(ldAccept), .ldCancel(ldCancel),
	.stValid(stValid), .stAddr(stAddr), .stData(stData), .stLocal(stLocal),
	.stAccept(stAccept), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
	.memWData(memWData), .memSplitSecond(memSplitSecond), .bufOccupied(bufOccupied));

// ---- sim/testbench.sv ----
// Self-checking bench for the store buffer hazard unit
`timescale 1ns/1ps
module testbench;
	logic mclk = 0, sys_rst = 1, clkEn = 1, mmuEnable = 0, ldValid = 0, ldTranslated = 0;
	logic ldCirc = 0, stValid = 0, stLocal = 1, stTranslated = 0;
	logic [31:0] ldAddr = 0, circBase = 0, stAddr = 0, stData = 0, rnd = 32'hD2334147, r;
	logic [15:0] circIndex = 0, circLength = 16'h10;
	logic [1:0] ldSize = 0, sz;
	logic [3:0] stByteEn = 4'h1;
	wire ldAccept, ldCancel, stAccept, memReq, memWrite, memSplitSecond, bufOccupied;
	wire [31:0] memAddr, memWData;
	wire [3:0] memByteEn;
	int num_errors = 0, compares = 0, cancels;
	sbh_store_buffer_hazard_unit dut (.mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn),
		.mmuEnable(mmuEnable), .ldValid(ldValid), .ldAddr(ldAddr), .ldSize(ldSize),
		.ldTranslated(ldTranslated), .ldCirc(ldCirc), .circBase(circBase),
		.circIndex(circIndex), .circLength(circLength), .ldAccept(ldAccept),
		.ldCancel(ldCancel), .stValid(stValid), .stAddr(stAddr), .stByteEn(stByteEn),
		.stData(stData), .stLocal(stLocal), .stTranslated(stTranslated), .stAccept(stAccept),
		.memReq(memReq), .memWrite(memWrite), .memAddr(memAddr), .memByteEn(memByteEn),
		.memWData(memWData), .memSplitSecond(memSplitSecond), .bufOccupied(bufOccupied));
	sbh_mem_model mm (.mclk(mclk), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
		.memByteEn(memByteEn), .memWData(memWData));
	initial forever #5 mclk = ~mclk;
	// ==========
	// Helpers: random source, expected conflict, compare
	function automatic logic [31:0] nxt();
		for (int i = 0; i < 16; i++) rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
		return rnd;
	endfunction
	// Lane overlap within the same word; page mode drops the upper bits
	function automatic logic hit(input logic [31:0] sa, la, input logic [3:0] be,
		input logic [1:0] s, input logic pg);
		logic [3:0] lm;
		lm = (s == 2'h0 ? 4'h1 : s == 2'h1 ? 4'h3 : 4'hF) << la[1:0];
		return (be & lm) != 4'h0 && sa[9:2] == la[9:2] && (pg || sa[31:10] == la[31:10]);
	endfunction
	task automatic check(input string nm, input logic [31:0] ex, got);
		compares++;
		if (got !== ex) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// Hold each request until its accept is seen before the deciding edge;
	// keep leaves the load strobe up so a back-to-back load needs no re-raise
	task automatic req(input logic l, s, keep);
		if (l && !ldValid) ldValid = 1'b1;
		if (s) stValid = 1'b1;
		for (int n = 0; n < 20 && (l || s); n++) begin
			#4;
			if (ldCancel === 1'b1) cancels++;
			if (ldAccept === 1'b1) l = 1'b0;
			if (stAccept === 1'b1) s = 1'b0;
			@(negedge mclk);
			if (!l && !keep && ldValid) ldValid = 1'b0;
			if (!s && stValid) stValid = 1'b0;
		end
		check("handshake", 0, l | s);
	endtask
	// Store alongside a harmless load, then the load under test
	task automatic pair(input logic [31:0] la, input logic [1:0] s, input logic circ);
		logic e;
		logic [31:0] m;
		int wi, ri;
		e = stLocal && hit(stAddr, la, stByteEn, s, mmuEnable && (ldTranslated || stTranslated));
		m = {{8{stByteEn[3]}}, {8{stByteEn[2]}}, {8{stByteEn[1]}}, {8{stByteEn[0]}}};
		mm.trace.delete();
		ldAddr = stAddr ^ 32'h200;
		ldSize = 2'h0;
		req(1, 1, 1);
		ldAddr = la;
		ldSize = circ ? 2'h2 : s;
		ldCirc = circ;
		cancels = 0;
		req(1, 0, 0);
		ldCirc = 0;
		repeat (4) @(negedge mclk);
		wi = -1;
		ri = -1;
		foreach (mm.trace[i]) begin
			if (mm.trace[i] === {1'b1, stAddr[31:2]}) wi = i;
			if (mm.trace[i] === {1'b0, la[31:2]}) ri = i;
		end
		check("cancel", e, cancels != 0);
		check("order", stLocal ? e : 1'b1, wi < ri);
		check("data", stData & m, mm.mem[stAddr[31:2]] & m);
	endtask
	task automatic print_verdict;
		$display("Comparisons %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		print_verdict;
	end
	// ==========
	// Main sequence
	initial begin
		repeat (12) @(negedge mclk);
		sys_rst = 0;
		@(negedge mclk);
		// Wrapping circular loads onto a buffered byte, no gap in between
		for (int k = 0; k < 2; k++) begin
			circBase = k ? 32'hD0001000 : 32'hD0001008;
			circLength = k ? 16'h14 : 16'h18;
			circIndex = k ? 16'h12 : 16'h16;
			stAddr = circBase + 32'h1;
			stByteEn = 4'h2;
			stData = nxt();
			pair(circBase, 2'h1, 1'b1);
		end
		// Random stores and loads, near and far, with translation mixed in
		for (int k = 0; k < 60; k++) begin
			stAddr = nxt();
			stData = nxt();
			r = nxt();
			stByteEn = r[3:0] ? r[3:0] : 4'h8;
			stLocal = r[4] | r[5];
			{mmuEnable, ldTranslated, stTranslated} = r[8:6];
			sz = r[10:9] == 2'h3 ? 2'h2 : r[10:9];
			pair({r[11] ? stAddr[31:10] : ~stAddr[31:10], r[12] ? stAddr[9:2] : r[20:13],
				r[22:21] & ~((2'h1 << sz) - 2'h1)}, sz, 1'b0);
		end
		// Frozen clock enable must keep the parked entry; it drains once running
		stLocal = 1'b1;
		mmuEnable = 1'b0;
		ldSize = 2'h0;
		ldAddr = stAddr ^ 32'h200;
		req(1, 1, 0);
		clkEn = 1'b0;
		repeat (3) @(negedge mclk);
		check("frozen entry", 1, bufOccupied);
		clkEn = 1'b1;
		repeat (2) @(negedge mclk);
		check("drained entry", 0, bufOccupied);
		// Lone store goes straight to memory with no load beside it
		stData = nxt();
		stByteEn = 4'hF;
		req(0, 1, 0);
		repeat (2) @(negedge mclk);
		check("lone store", stData, mm.mem[stAddr[31:2]]);
		print_verdict;
	end
endmodule // testbench
